// ===== src/status_defs_defs.vh
// Purpose: Constants for the sink status channel generator
// Assumes: 32-bit register bus, byte addresses, 8-bit address space
// Notes:   Field ranges are given as msb:lsb for direct use in selects
`ifndef STATUS_DEFS_DEFS_VH
`define STATUS_DEFS_DEFS_VH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define ADDR_CAL_CFG     8'h00
`define ADDR_LINK_CFG    8'h04
`define ADDR_FIFO_CFG    8'h08
`define ADDR_CHAN_CFG    8'h0c
`define ADDR_CAL_WR      8'h10
`define ADDR_STATE       8'h14
`define ADDR_IRQ_STATUS  8'h18
`define ADDR_IRQ_CLEAR   8'h1c
`define ADDR_IRQ_ENABLE  8'h20

////////////////////////////////////////////////////////////////////////
// Field positions
`define F_REPEATS        7:0
`define F_LENGTH         24:16
`define F_DIVIDER        3:0
`define F_EDGE_SEL       4
`define F_REACTION       9:8
`define F_TRAIN          19:16
`define F_DIP4ERR        27:24
`define F_SET_LEVEL      8:0
`define F_CLEAR_LEVEL    24:16
`define F_CHAN_COUNT     7:0
`define F_CAL_CHANNEL    7:0
`define F_CAL_SLOT       24:16

////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_CAL_CFG      32'h000f_0000
`define RST_LINK_CFG     32'h0101_0001
`define RST_FIFO_CFG     32'h0040_0010
`define RST_CHAN_CFG     32'h0000_000f

////////////////////////////////////////////////////////////////////////
// Status codes, reactions, limits
`define CODE_STARVING    2'h0
`define CODE_HUNGRY      2'h1
`define CODE_SATISFIED   2'h2
`define CODE_FRAMING     2'h3
`define REACT_SATISFIED  2'h0
`define REACT_FRAMING    2'h1
`define REACT_CURRENT    2'h2
`define LEVEL_MIN        9'h001
`define LEVEL_MAX        9'h1fc
`define DIP2_INIT        2'h3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== src/sync_2ff.v
// Purpose: Two flip-flop synchroniser for levels from another domain
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage

module sync_2ff #(
	parameter WIDTH = 1
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
			reg meta_reg;
			reg stable_reg;
			always @(posedge aclk) begin
				if (!aresetn) begin
					meta_reg   <= 1'b0;
					stable_reg <= 1'b0;
				end else begin
					meta_reg   <= async_in[g];
					stable_reg <= meta_reg;
				end
			end
			assign sync_out[g] = stable_reg;
		end
	endgenerate

endmodule

// ===== src/dip2_step.v
// Purpose: One step of the two-bit diagonal parity over status words
// Assumes: Accumulator starts at the init value after each framing word
// Notes:   Rotate then fold in the word, so bit position matters

module dip2_step (
	input  wire [1:0] acc,
	input  wire [1:0] word,
	output wire [1:0] acc_next
);

	assign acc_next = {acc[0], acc[1]} ^ word;

endmodule

// ===== src/sink_status_channel_gen.v
// Purpose: Drives the receive status channel (rstat, rsclk)
// Assumes: rdclk comes from outside; pulses and levels on aclk
// Notes:   Registers on AXI4-Lite; one write and one read at a time
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`include "status_defs_defs.vh"

module sink_status_channel_gen #(
	parameter CAL_DEPTH = 512,
	parameter CHANNELS  = 256
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        rdclk,
	input  wire        training_seq_rx,
	input  wire        ctrl_word_rx,
	input  wire        ctrl_dip4_ok,
	input  wire [8:0]  fifo_empty_locations,
	input  wire        chan_status_we,
	input  wire [7:0]  chan_status_channel,
	input  wire [1:0]  chan_status_code,
	output reg         rsclk,
	output reg  [1:0]  rstat,
	output reg         sink_fifo_nearly_full_n,
	output reg         in_frame,
	output reg         irq
);

	localparam PH_FRAME = 2'd0;
	localparam PH_SLOT  = 2'd1;
	localparam PH_DIP2  = 2'd2;

	////////////////////////////////////////////////////////////////////
	// Functions

	// Word index of a mapped register, or 4'hf when unmapped
	function [3:0] reg_index;
		input [7:0] addr;
		begin
			if (addr[1:0] != 2'b00 || addr > `ADDR_IRQ_ENABLE)
				reg_index = 4'hf;
			else
				reg_index = addr[5:2];
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b])
					merge[b*8 +: 8] = data[b*8 +: 8];
			end
		end
	endfunction

	function [8:0] clamp;
		input [8:0] v;
		input [8:0] lo;
		input [8:0] hi;
		begin
			if (v < lo)
				clamp = lo;
			else if (v > hi)
				clamp = hi;
			else
				clamp = v;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Register state

	reg [31:0] cal_cfg_reg;
	reg [31:0] link_cfg_reg;
	reg [31:0] fifo_cfg_reg;
	reg [31:0] chan_cfg_reg;
	reg [2:0]  irq_status_reg;
	reg [2:0]  irq_enable_reg;
	reg [7:0]  aw_addr_reg;
	reg        aw_have_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	reg        w_have_reg;
	reg [7:0]  cal_mem [0:CAL_DEPTH-1];
	reg [1:0]  chan_mem [0:CHANNELS-1];
	reg        rdclk_prev_reg;
	reg [3:0]  div_cnt_reg;
	reg [1:0]  phase_reg;
	reg [8:0]  slot_reg;
	reg [7:0]  rep_reg;
	reg [1:0]  dip2_reg;
	reg [3:0]  train_cnt_reg;
	reg [3:0]  err_cnt_reg;

	wire [3:0] wr_idx = reg_index(aw_addr_reg);
	wire       wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire       cal_wr = wr_fire && wr_idx == `ADDR_CAL_WR >> 2;
	wire       irq_clr = wr_fire && wr_idx == `ADDR_IRQ_CLEAR >> 2;
	wire [31:0] wr_word = merge(32'h0000_0000, w_data_reg, w_strb_reg);

	// Settings are read live on every use, so rewriting takes effect
	// at the next slot without any restart
	wire [7:0] repeats   = cal_cfg_reg[`F_REPEATS];
	wire [8:0] cal_len   = cal_cfg_reg[`F_LENGTH];
	wire [3:0] divider   = link_cfg_reg[`F_DIVIDER];
	wire       edge_sel  = link_cfg_reg[`F_EDGE_SEL];
	wire [1:0] reaction  = link_cfg_reg[`F_REACTION];
	wire [3:0] train_cfg = link_cfg_reg[`F_TRAIN];
	wire [3:0] err_cfg   = link_cfg_reg[`F_DIP4ERR];
	wire [7:0] chan_last = chan_cfg_reg[`F_CHAN_COUNT];
	wire [3:0] train_eff = (train_cfg == 4'h0) ? 4'h1 : train_cfg;
	wire [3:0] err_eff   = (err_cfg == 4'h0) ? 4'h1 : err_cfg;
	wire [8:0] set_eff = clamp(fifo_cfg_reg[`F_SET_LEVEL],
		`LEVEL_MIN, `LEVEL_MAX);
	wire [8:0] clr_eff = clamp(fifo_cfg_reg[`F_CLEAR_LEVEL],
		set_eff, `LEVEL_MAX);

	////////////////////////////////////////////////////////////////////
	// Link clock sampling and status clock divider

	wire rdclk_s;

	sync_2ff #(
		.WIDTH    (1)
	) rdclk_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (rdclk),
		.sync_out (rdclk_s)
	);

	wire rdclk_rise = rdclk_s && !rdclk_prev_reg;
	wire div_wrap = rdclk_rise && div_cnt_reg >= divider;
	// Next edge is rising when rsclk is low; pick the chosen edge
	wire stat_tick = div_wrap && (rsclk == edge_sel);

	always @(posedge aclk) begin
		if (!aresetn) begin
			rdclk_prev_reg <= 1'b0;
			div_cnt_reg    <= 4'h0;
			rsclk          <= 1'b0;
		end else begin
			rdclk_prev_reg <= rdclk_s;
			if (div_wrap) begin
				div_cnt_reg <= 4'h0;
				rsclk       <= ~rsclk;
			end else if (rdclk_rise) begin
				div_cnt_reg <= div_cnt_reg + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Calendar and per-channel status storage

	// Identity preload: slot n names channel n modulo 256
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < CAL_DEPTH; i = i + 1)
				cal_mem[i] <= i[7:0];
		end else if (cal_wr) begin
			cal_mem[wr_word[`F_CAL_SLOT]] <=
				wr_word[`F_CAL_CHANNEL];
		end
	end

	integer j;
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (j = 0; j < CHANNELS; j = j + 1)
				chan_mem[j] <= `CODE_STARVING;
		end else if (chan_status_we) begin
			chan_mem[chan_status_channel] <= chan_status_code;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Framing and nearly-full state

	wire nearly_full = !sink_fifo_nearly_full_n;
	wire force_oof = nearly_full && reaction == `REACT_FRAMING;
	wire train_done = training_seq_rx &&
		train_cnt_reg + 4'h1 >= train_eff;
	wire dip4_lost = ctrl_word_rx && !ctrl_dip4_ok &&
		err_cnt_reg + 4'h1 >= err_eff;
	wire ev_framed = !in_frame && train_done && !force_oof;
	wire ev_lost = in_frame && (dip4_lost || force_oof);
	wire nf_set = !nearly_full && fifo_empty_locations <= set_eff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			in_frame                <= 1'b0;
			train_cnt_reg           <= 4'h0;
			err_cnt_reg             <= 4'h0;
			sink_fifo_nearly_full_n <= 1'b1;
		end else begin
			if (nf_set)
				sink_fifo_nearly_full_n <= 1'b0;
			else if (nearly_full && fifo_empty_locations >= clr_eff)
				sink_fifo_nearly_full_n <= 1'b1;
			if (ev_lost) begin
				in_frame      <= 1'b0;
				train_cnt_reg <= 4'h0;
			end else if (ev_framed) begin
				in_frame      <= 1'b1;
				err_cnt_reg   <= 4'h0;
			end else if (!in_frame && training_seq_rx) begin
				train_cnt_reg <= train_cnt_reg + 4'h1;
			end else if (in_frame && ctrl_word_rx) begin
				err_cnt_reg <= ctrl_dip4_ok ? 4'h0 :
					err_cnt_reg + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status sequencer

	wire [7:0] slot_chan = cal_mem[slot_reg];
	reg  [1:0] slot_code;

	always @* begin
		if (slot_chan > chan_last)
			slot_code = `CODE_SATISFIED;
		else if (nearly_full && reaction == `REACT_SATISFIED)
			slot_code = `CODE_SATISFIED;
		else
			slot_code = chan_mem[slot_chan];
	end

	wire [1:0] dip2_next;

	dip2_step dip2 (
		.acc      (dip2_reg),
		.word     (slot_code),
		.acc_next (dip2_next)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= PH_FRAME;
			slot_reg  <= 9'h000;
			rep_reg   <= 8'h00;
			dip2_reg  <= `DIP2_INIT;
			rstat     <= `CODE_FRAMING;
		end else if (stat_tick) begin
			if (!in_frame || force_oof) begin
				rstat     <= `CODE_FRAMING;
				phase_reg <= PH_FRAME;
				slot_reg  <= 9'h000;
				rep_reg   <= 8'h00;
			end else begin
				case (phase_reg)
				PH_FRAME: begin
					rstat     <= `CODE_FRAMING;
					dip2_reg  <= `DIP2_INIT;
					phase_reg <= PH_SLOT;
				end
				PH_SLOT: begin
					rstat    <= slot_code;
					dip2_reg <= dip2_next;
					if (slot_reg >= cal_len) begin
						slot_reg <= 9'h000;
						if (rep_reg >= repeats) begin
							rep_reg   <= 8'h00;
							phase_reg <= PH_DIP2;
						end else begin
							rep_reg <= rep_reg + 8'h01;
						end
					end else begin
						slot_reg <= slot_reg + 9'h001;
					end
				end
				PH_DIP2: begin
					rstat     <= dip2_reg;
					phase_reg <= PH_FRAME;
				end
				default: begin
					phase_reg <= PH_FRAME;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over a clear in the same cycle

	wire [2:0] events = {nf_set, ev_lost, ev_framed};

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= 3'h0;
			irq            <= 1'b0;
		end else begin
			irq_status_reg <= (irq_status_reg &
				~(irq_clr ? wr_word[2:0] : 3'h0)) | events;
			irq <= |(irq_status_reg & irq_enable_reg);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus write side

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready  <= 1'b0;
			s_axi_wready   <= 1'b0;
			s_axi_bvalid   <= 1'b0;
			s_axi_bresp    <= `RESP_OKAY;
			aw_have_reg    <= 1'b0;
			aw_addr_reg    <= 8'h00;
			w_have_reg     <= 1'b0;
			w_data_reg     <= 32'h0000_0000;
			w_strb_reg     <= 4'h0;
			cal_cfg_reg    <= `RST_CAL_CFG;
			link_cfg_reg   <= `RST_LINK_CFG;
			fifo_cfg_reg   <= `RST_FIFO_CFG;
			chan_cfg_reg   <= `RST_CHAN_CFG;
			irq_enable_reg <= 3'h0;
		end else begin
			if (s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_have_reg   <= 1'b1;
				aw_addr_reg   <= s_axi_awaddr;
			end else if (s_axi_awvalid && !aw_have_reg) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_have_reg   <= 1'b1;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
			end else if (s_axi_wvalid && !w_have_reg) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx == 4'hf) ? `RESP_SLVERR :
					`RESP_OKAY;
				case (wr_idx)
				`ADDR_CAL_CFG >> 2:
					cal_cfg_reg <= merge(cal_cfg_reg, w_data_reg,
						w_strb_reg);
				`ADDR_LINK_CFG >> 2:
					link_cfg_reg <= merge(link_cfg_reg, w_data_reg,
						w_strb_reg);
				`ADDR_FIFO_CFG >> 2:
					fifo_cfg_reg <= merge(fifo_cfg_reg, w_data_reg,
						w_strb_reg);
				`ADDR_CHAN_CFG >> 2:
					chan_cfg_reg <= merge(chan_cfg_reg, w_data_reg,
						w_strb_reg);
				`ADDR_IRQ_ENABLE >> 2:
					irq_enable_reg <= wr_word[2:0];
				default: begin
				end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus read side

	reg [31:0] rd_word;
	wire [3:0] rd_idx = reg_index(s_axi_araddr);

	always @* begin
		case (rd_idx)
		`ADDR_CAL_CFG >> 2:    rd_word = cal_cfg_reg;
		`ADDR_LINK_CFG >> 2:   rd_word = link_cfg_reg;
		`ADDR_FIFO_CFG >> 2:   rd_word = fifo_cfg_reg;
		`ADDR_CHAN_CFG >> 2:   rd_word = chan_cfg_reg;
		`ADDR_STATE >> 2:
			rd_word = {26'h000_0000, phase_reg, 2'b00,
				nearly_full, in_frame};
		`ADDR_IRQ_STATUS >> 2: rd_word = {29'h0000_0000, irq_status_reg};
		`ADDR_IRQ_ENABLE >> 2: rd_word = {29'h0000_0000, irq_enable_reg};
		default:               rd_word = 32'h0000_0000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= (rd_idx == 4'hf) ? `RESP_SLVERR :
					`RESP_OKAY;
			end else if (s_axi_rvalid) begin
				if (s_axi_rready)
					s_axi_rvalid <= 1'b0;
			end else if (s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// ===== bench/status_gen_checker.sv
// Purpose: Port checks for the status channel generator
// Assumes: 4 ns bus clock, 48 ns data clock
// Notes:   Sees only top-level ports, so register values stay out
module status_gen_checker (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awready,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic        training_seq_rx,
	input logic        rsclk,
	input logic [1:0]  rstat,
	input logic        in_frame,
	input logic        sink_fifo_nearly_full_n,
	input logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("wready longer than one cycle");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read data late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	oof_framing_a: assert property (!$past(in_frame) && !in_frame
		&& $changed(rstat) |-> rstat == 2'b11)
		else $error("status sent while out of frame");
	stat_edge_a: assert property ($changed(rstat)
		|-> $changed(rsclk))
		else $error("status word moved off a status clock edge");
	// Data clock is 12 bus cycles, so no status clock phase is shorter
	clk_slow_a: assert property ($changed(rsclk)
		|=> $stable(rsclk)[*8])
		else $error("status clock phase too short");
	frame_cause_a: assert property ($rose(in_frame) |->
		$past(training_seq_rx) || $past(training_seq_rx, 2)
		|| $past(training_seq_rx, 3))
		else $error("in frame without training");
	c_frame: cover property ($rose(in_frame));
	c_full: cover property ($fell(sink_fifo_nearly_full_n));
	c_irq: cover property ($rose(irq));
endmodule

bind sink_status_channel_gen status_gen_checker chk (.aclk, .aresetn,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .training_seq_rx, .rsclk, .rstat,
	.in_frame, .sink_fifo_nearly_full_n, .irq);

// ===== bench/status_reader.sv
// Purpose: Far-side transmitter that reads the status link
// Assumes: Edge select matches the generator setting
// Notes:   Samples mid-period, on the edge the word does not move on
module status_reader (
	input  logic       aclk,
	input  logic       rsclk,
	input  logic [1:0] rstat,
	input  logic       edge_sel,
	output logic       training_seq_rx,
	output logic       ctrl_word_rx,
	output logic       ctrl_dip4_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] words[$];
	logic       rsclk_q = 1'b0;
	initial begin
		training_seq_rx = 1'b0;
		ctrl_word_rx = 1'b0;
		ctrl_dip4_ok = 1'b0;
	end
	always @(posedge aclk) begin
		rsclk_q <= rsclk;
		if (rsclk_q !== rsclk && rsclk === edge_sel)
			words.push_back(rstat);
	end
	// Parity flag is only meaningful with a control word; idle shows junk
	task automatic pulse(input bit train, input bit ok);
		@(posedge aclk);
		training_seq_rx <= train;
		ctrl_word_rx <= !train;
		ctrl_dip4_ok <= ok;
		@(posedge aclk);
		training_seq_rx <= 1'b0;
		ctrl_word_rx <= 1'b0;
		ctrl_dip4_ok <= !ok;
	endtask
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench for the status channel generator
// Assumes: Calendar of 2 slots repeated twice, 16 channels
// Notes:   Frame start found by searching, so link phase is free
`include "status_defs_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, rdclk, rsclk, edge_sel, b;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, chan_status_channel;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, chan_status_code, rstat, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, chan_status_we, in_frame, irq;
	logic        training_seq_rx, ctrl_word_rx, ctrl_dip4_ok;
	logic        sink_fifo_nearly_full_n;
	logic [8:0]  fifo_empty_locations;
	logic [31:0] rst[4] = '{`RST_CAL_CFG, `RST_LINK_CFG, `RST_FIFO_CFG,
		`RST_CHAN_CFG};
	int          miscompares, n_compared, code3, n;
	sink_status_channel_gen DUT (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rdclk,
		.training_seq_rx, .ctrl_word_rx, .ctrl_dip4_ok,
		.fifo_empty_locations, .chan_status_we, .chan_status_channel,
		.chan_status_code, .rsclk, .rstat, .sink_fifo_nearly_full_n,
		.in_frame, .irq);
	status_reader link (.aclk, .rsclk, .rstat, .edge_sel, .training_seq_rx,
		.ctrl_word_rx, .ctrl_dip4_ok);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Odd start offset keeps the data clock unrelated in phase
	initial begin
		rdclk = 1'b0;
		#1.3;
		forever #24 rdclk = ~rdclk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic timeout();
		miscompares++;
		$display("wait limit reached at %0t", $time);
		stop_test();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 64);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (k >= 64) timeout();
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 64);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (k >= 64) timeout();
	endtask
	task automatic wait_frame();
		n = 0;
		while (in_frame !== 1'b1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 200) timeout();
	endtask
	task automatic grab(input int cnt);
		repeat (100) @(posedge aclk);
		link.words.delete();
		n = 0;
		while (link.words.size() < cnt && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 3000) timeout();
	endtask
	// Model: slot 0 is channel 3, slot 1 is channel 20 (beyond count)
	task automatic check_frame(input bit sat);
		logic [1:0] acc;
		logic [1:0] e;
		int i;
		grab(14);
		i = 0;
		while (i < 7 && !(link.words[i] == 3 && link.words[i+1] != 3)) i++;
		acc = `DIP2_INIT;
		for (int k = 0; k < 4; k++) begin
			e = (k % 2 == 0 && !sat) ? 2'(code3) : `CODE_SATISFIED;
			check(link.words[i+1+k], e);
			acc = {acc[0], acc[1]} ^ e;
		end
		check(link.words[i+5], acc);
		check(link.words[i+6], `CODE_FRAMING);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'he1e5));
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, chan_status_we} = '0;
		s_axi_wstrb = 4'hf;
		{chan_status_channel, chan_status_code} = '0;
		fifo_empty_locations = 9'h1ff;
		edge_sel = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			rd(8'(4 * k));
			check(d, rst[k]);
		end
		rd(8'h24);
		check(resp, `RESP_SLVERR);
		check(d, 32'h0000_0000);
		wr(8'h24, 32'hffff_ffff);
		check(resp, `RESP_SLVERR);
		wr(`ADDR_FIFO_CFG, 32'h01ff_0000);
		check(resp, `RESP_OKAY);
		// Levels are stored as written; clamping acts on use only
		rd(`ADDR_FIFO_CFG);
		check(d, 32'h01ff_0000);
		wr(`ADDR_FIFO_CFG, 32'h0040_0010);
		$display("test registers done");
		wr(`ADDR_CAL_CFG, 32'h0001_0001);
		wr(`ADDR_CAL_WR, 32'h0000_0003);
		wr(`ADDR_CAL_WR, 32'h0001_0014);
		code3 = $urandom % 3;
		chan_status_we <= 1'b1;
		chan_status_channel <= 8'h03;
		chan_status_code <= 2'(code3);
		@(posedge aclk);
		chan_status_we <= 1'b0;
		wr(`ADDR_IRQ_ENABLE, 32'h0000_0007);
		link.pulse(1'b1, 1'b1);
		wait_frame();
		repeat (3) @(posedge aclk);
		check(irq, 1'b1);
		rd(`ADDR_IRQ_STATUS);
		check(d, 32'h0000_0001);
		rd(`ADDR_STATE);
		check(d[1:0], 2'b01);
		wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
		repeat (3) @(posedge aclk);
		check(irq, 1'b0);
		$display("test framing done");
		for (int k = 0; k < 2; k++) begin
			wr(`ADDR_LINK_CFG, 32'h0101_0000 | (k << 4) | k);
			edge_sel <= 1'(k);
			check_frame(1'b0);
			b = rsclk;
			for (int h = 0; h < 2; h++) begin
				n = 0;
				while (rsclk === b && n < 200) begin
					@(posedge aclk);
					n++;
				end
				b = rsclk;
				if (n >= 200) timeout();
			end
			check(32'((n + 3) / (6 * (k + 1))), 32'h2);
		end
		$display("test link clock done");
		edge_sel <= 1'b0;
		for (int r = 0; r < 3; r++) begin
			wr(`ADDR_LINK_CFG, 32'h0101_0000 | (r << 8));
			fifo_empty_locations <= 9'($urandom_range(16, 1));
			repeat (3) @(posedge aclk);
			check(sink_fifo_nearly_full_n, 1'b0);
			if (r == 1) begin
				grab(4);
				check({in_frame, link.words[3]}, 3'h3);
			end else
				check_frame(r == 0);
			fifo_empty_locations <= 9'd40;
			repeat (3) @(posedge aclk);
			check(sink_fifo_nearly_full_n, 1'b0);
			fifo_empty_locations <= 9'($urandom_range(511, 64));
			repeat (3) @(posedge aclk);
			check(sink_fifo_nearly_full_n, 1'b1);
			link.pulse(1'b1, 1'b1);
			wait_frame();
		end
		$display("test reactions done");
		wr(`ADDR_LINK_CFG, 32'h0201_0000);
		for (int k = 0; k < 3; k++) begin
			link.pulse(1'b0, k == 1);
			repeat (4) @(posedge aclk);
			check(in_frame, 1'b1);
		end
		link.pulse(1'b0, 1'b0);
		repeat (4) @(posedge aclk);
		check(in_frame, 1'b0);
		grab(4);
		check(link.words[3], `CODE_FRAMING);
		$display("test parity loss done");
		stop_test();
	end
endmodule
